// ==== hdl/rsi_pkg.sv ====
package rsi_pkg;
   typedef enum logic [2:0] {
      RSI_ST_RUN  = 3'b001,
      RSI_ST_HOLD = 3'b010,
      RSI_ST_WAIT = 3'b100
   } rsi_state_e;

   typedef enum logic [1:0] {
      RSI_SRC_EXT = 2'b00,
      RSI_SRC_POC = 2'b01,
      RSI_SRC_WDT = 2'b10,
      RSI_SRC_LVD = 2'b11
   } rsi_src_e;

   typedef struct packed {
      logic [7:0]  watchdog_enable_reg;
      logic [7:0]  irq_request_flags;
      logic [7:0]  irq_mask_flags;
      logic [7:0]  irq_priority_flags;
      logic [7:0]  ext_rise_edge_enable;
      logic [7:0]  ext_fall_edge_enable;
      logic [7:0]  uart_a_rx_buf;
      logic [7:0]  uart_a_tx_shift;
      logic [7:0]  uart_a_mode;
      logic [7:0]  uart_a_err;
      logic [7:0]  uart_a_baud_ctrl;
      logic [7:0]  uart_b_rx_buf;
      logic [7:0]  uart_b_tx_buf;
      logic [7:0]  uart_b_mode;
      logic [7:0]  uart_b_err;
      logic [7:0]  uart_b_tx_stat;
      logic [7:0]  uart_b_clk_sel;
      logic [7:0]  uart_b_baud_ctrl;
      logic [7:0]  uart_b_control;
      logic [7:0]  uart_b_in_switch;
      logic [15:0] conv_result_wide;
      logic [7:0]  conv_result_narrow;
      logic [7:0]  conv_mode;
      logic [7:0]  conv_channel;
      logic [7:0]  conv_port_cfg;
      logic [15:0] muldiv_remainder;
      logic [15:0] muldiv_data_a;
      logic [15:0] muldiv_data_b;
      logic [7:0]  muldiv_control;
      logic [7:0]  evt_counter;
      logic [7:0]  evt_compare;
      logic [7:0]  evt_clk_sel;
      logic [7:0]  evt_mode;
      logic [7:0]  itv_compare;
      logic [7:0]  itv_mode;
      logic [7:0]  carrier_control;
      logic [7:0]  sync_serial_regs;
      logic [7:0]  i2c_regs;
      logic [7:0]  watch_mode;
      logic [7:0]  clkout_select;
      logic [7:0]  key_return_mode;
   } rsi_init_s;
endpackage

// ==== hdl/rsi_regs.svh ====
`ifndef RSI_REGS_SVH
`define RSI_REGS_SVH
// apb byte offsets
`define RSI_OFF_CAUSE    12'h000
`define RSI_OFF_LVCTRL   12'h004
`define RSI_OFF_LVLEVEL  12'h008
`define RSI_OFF_IRQSTAT  12'h00C
`define RSI_OFF_IRQMASK  12'h010
`define RSI_OFF_STATUS   12'h014
// reset-cause flag positions
`define RSI_BIT_WDT_FLAG 4
`define RSI_BIT_LV_FLAG  0
// interrupt status positions
`define RSI_IRQ_DONE     0
`define RSI_IRQ_WDT      1
`define RSI_IRQ_LVD      2
`define RSI_IRQ_W        3
// reset values
`define RSI_WATCHDOG_ENABLE_REG_OPT0    8'h1A
`define RSI_WATCHDOG_ENABLE_REG_OPT1    8'h9A
`define RSI_V00          8'h00
`define RSI_VFF          8'hFF
`define RSI_V01          8'h01
`define RSI_V1F          8'h1F
`define RSI_V16          8'h16
`define RSI_W0000        16'h0000
// oscillation stabilisation wait, in pclk cycles
`define RSI_STAB_CYCLES  16
`endif

// ==== hdl/rsi_reset_state_initializer.sv ====
// Functional notes
// - during reset or the stabilisation wait every state except the program counter holds its reset value, but presetn low forces watchdog enable to 1AH.
// - the watchdog enable value is 1AH or 9AH, chosen by the option byte bit.
// - watchdog flag cleared by pin or power-on reset, set by watchdog reset, held by low-voltage reset; low-voltage flag held by watchdog reset, set by low-voltage reset.
// - low-voltage control and level registers clear to 00H except on a low-voltage reset, which keeps them.
// - interrupt request and edge enables clear to 00H, mask and priority flags set to FFH.
// - first uart buffers FFH, mode 01H, error 00H, baud 1FH.
// - second uart buffers and baud FFH, mode 01H, control 16H, other registers 00H.
// - converter results, mode, channel and port configuration clear to zero.
// - multiplier/divider remainder and data clear to 0000H, control to 00H.
// - event counter and interval timer registers and the carrier control clear to 00H.
// - clocked serial, i2c, watch mode, clock output select and key return mode clear to 00H.
// - reading the reset-cause register clears it, as do pin and power-on resets.
`timescale 1ns/100ps
`include "rsi_regs.svh"
module rsi_reset_state_initializer #(
   parameter int STAB_CYCLES = `RSI_STAB_CYCLES
) (
   // apb
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // reset requests and option byte
   input  wire logic              req_ext,
   input  wire logic              req_poc,
   input  wire logic              req_wdt,
   input  wire logic              req_lvd,
   input  wire logic              wdt_opt,
   // peripheral side
   output rsi_pkg::rsi_init_s     init_vals,
   output logic                   periph_rst_n,
   output logic                   cpu_run,
   output logic                   irq
);
   import rsi_pkg::*;

   localparam int CW = 16;

   rsi_state_e      state;
   rsi_state_e      next_state;
   rsi_src_e        src;
   rsi_src_e        next_src;
   rsi_src_e        enc_src;
   logic [CW-1:0]   cnt;
   logic [CW-1:0]   next_cnt;
   logic            any_req;
   logic            wait_done;
   rsi_init_s       next_init;
   logic            wdt_flag;
   logic            next_wdt_flag;
   logic            lv_flag;
   logic            next_lv_flag;
   logic [7:0]      lv_ctrl;
   logic [7:0]      next_lv_ctrl;
   logic [7:0]      lv_level;
   logic [7:0]      next_lv_level;
   logic [`RSI_IRQ_W-1:0] irq_stat;
   logic [`RSI_IRQ_W-1:0] next_irq_stat;
   logic [`RSI_IRQ_W-1:0] irq_mask;
   logic [`RSI_IRQ_W-1:0] next_irq_mask;
   logic [`RSI_IRQ_W-1:0] irq_ev;
   logic            next_irq;
   logic [31:0]     next_prdata;
   logic            next_pready;
   logic            next_pslverr;
   logic            setup;
   logic            wr_done;
   logic            rd_done;
   logic            mapped;
   logic [31:0]     rd_mux;

   function automatic rsi_init_s reset_image(input logic opt);
      rsi_init_s v;
      v = '0;
      v.watchdog_enable_reg  = opt ? `RSI_WATCHDOG_ENABLE_REG_OPT1 : `RSI_WATCHDOG_ENABLE_REG_OPT0;
      v.irq_request_flags    = `RSI_V00;
      v.irq_mask_flags       = `RSI_VFF;
      v.irq_priority_flags   = `RSI_VFF;
      v.ext_rise_edge_enable = `RSI_V00;
      v.ext_fall_edge_enable = `RSI_V00;
      v.uart_a_rx_buf        = `RSI_VFF;
      v.uart_a_tx_shift      = `RSI_VFF;
      v.uart_a_mode          = `RSI_V01;
      v.uart_a_err           = `RSI_V00;
      v.uart_a_baud_ctrl     = `RSI_V1F;
      v.uart_b_rx_buf        = `RSI_VFF;
      v.uart_b_tx_buf        = `RSI_VFF;
      v.uart_b_mode          = `RSI_V01;
      v.uart_b_err           = `RSI_V00;
      v.uart_b_tx_stat       = `RSI_V00;
      v.uart_b_clk_sel       = `RSI_V00;
      v.uart_b_baud_ctrl     = `RSI_VFF;
      v.uart_b_control       = `RSI_V16;
      v.uart_b_in_switch     = `RSI_V00;
      v.conv_result_wide     = `RSI_W0000;
      v.conv_result_narrow   = `RSI_V00;
      v.conv_mode            = `RSI_V00;
      v.conv_channel         = `RSI_V00;
      v.conv_port_cfg        = `RSI_V00;
      v.muldiv_remainder     = `RSI_W0000;
      v.muldiv_data_a        = `RSI_W0000;
      v.muldiv_data_b        = `RSI_W0000;
      v.muldiv_control       = `RSI_V00;
      v.evt_counter          = `RSI_V00;
      v.evt_compare          = `RSI_V00;
      v.evt_clk_sel          = `RSI_V00;
      v.evt_mode             = `RSI_V00;
      v.itv_compare          = `RSI_V00;
      v.itv_mode             = `RSI_V00;
      v.carrier_control      = `RSI_V00;
      v.sync_serial_regs     = `RSI_V00;
      v.i2c_regs             = `RSI_V00;
      v.watch_mode           = `RSI_V00;
      v.clkout_select        = `RSI_V00;
      v.key_return_mode      = `RSI_V00;
      return v;
   endfunction

   // reset sequencing
   always_comb begin
      any_req = req_ext | req_poc | req_wdt | req_lvd;
      if (req_poc) begin
         enc_src = RSI_SRC_POC;
      end else if (req_ext) begin
         enc_src = RSI_SRC_EXT;
      end else if (req_wdt) begin
         enc_src = RSI_SRC_WDT;
      end else begin
         enc_src = RSI_SRC_LVD;
      end
      wait_done  = (state == RSI_ST_WAIT) && !any_req && (cnt == CW'(STAB_CYCLES - 1));
      next_state = state;
      next_src   = src;
      next_cnt   = cnt;
      case (state)
         RSI_ST_RUN: begin
            if (any_req) begin
               next_state = RSI_ST_HOLD;
               next_src   = enc_src;
            end
         end
         RSI_ST_HOLD: begin
            next_cnt = '0;
            if (any_req) begin
               next_src = enc_src;
            end else begin
               next_state = RSI_ST_WAIT;
            end
         end
         RSI_ST_WAIT: begin
            if (any_req) begin
               next_state = RSI_ST_HOLD;
               next_src   = enc_src;
            end else if (wait_done) begin
               next_state = RSI_ST_RUN;
            end else begin
               next_cnt = cnt + CW'(1);
            end
         end
         default: begin
            next_state = RSI_ST_HOLD;
            next_src   = RSI_SRC_POC;
         end
      endcase
      // values are forced for the whole reset period, not only at its end
      next_init = (next_state != RSI_ST_RUN) ? reset_image(wdt_opt) : init_vals;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state        <= RSI_ST_HOLD;
         src          <= RSI_SRC_POC;
         cnt          <= '0;
         init_vals    <= reset_image(1'b0);
         periph_rst_n <= 1'b0;
         cpu_run      <= 1'b0;
      end else begin
         state        <= next_state;
         src          <= next_src;
         cnt          <= next_cnt;
         init_vals    <= next_init;
         periph_rst_n <= (next_state == RSI_ST_RUN);
         cpu_run      <= (next_state == RSI_ST_RUN);
      end
   end

   // apb and software-visible state
   always_comb begin
      setup   = psel & ~penable;
      wr_done = psel & penable & pready & pwrite;
      rd_done = psel & penable & pready & ~pwrite;
      mapped  = 1'b1;
      rd_mux  = '0;
      case (paddr)
         `RSI_OFF_CAUSE: begin
            rd_mux[`RSI_BIT_WDT_FLAG] = wdt_flag;
            rd_mux[`RSI_BIT_LV_FLAG]  = lv_flag;
         end
         `RSI_OFF_LVCTRL:  rd_mux[7:0] = lv_ctrl;
         `RSI_OFF_LVLEVEL: rd_mux[7:0] = lv_level;
         `RSI_OFF_IRQSTAT: rd_mux[`RSI_IRQ_W-1:0] = irq_stat;
         `RSI_OFF_IRQMASK: rd_mux[`RSI_IRQ_W-1:0] = irq_mask;
         `RSI_OFF_STATUS:  rd_mux[4:0] = {state, src};
         default:          mapped = 1'b0;
      endcase
      next_pready  = setup;
      next_pslverr = setup & ~mapped;
      next_prdata  = (setup & ~pwrite) ? rd_mux : prdata;

      next_wdt_flag = wdt_flag;
      next_lv_flag  = lv_flag;
      if (rd_done && paddr == `RSI_OFF_CAUSE) begin
         next_wdt_flag = 1'b0;
         next_lv_flag  = 1'b0;
      end
      // a reset event wins over a read clear in the same cycle
      if (state == RSI_ST_HOLD) begin
         case (src)
            RSI_SRC_EXT, RSI_SRC_POC: begin
               next_wdt_flag = 1'b0;
               next_lv_flag  = 1'b0;
            end
            RSI_SRC_WDT: next_wdt_flag = 1'b1;
            RSI_SRC_LVD: next_lv_flag  = 1'b1;
            default: next_lv_flag = lv_flag;
         endcase
      end

      next_lv_ctrl  = lv_ctrl;
      next_lv_level = lv_level;
      if (state == RSI_ST_HOLD && src != RSI_SRC_LVD) begin
         next_lv_ctrl  = `RSI_V00;
         next_lv_level = `RSI_V00;
      end else if (wr_done && paddr == `RSI_OFF_LVCTRL) begin
         next_lv_ctrl = pwdata[7:0];
      end else if (wr_done && paddr == `RSI_OFF_LVLEVEL) begin
         next_lv_level = pwdata[7:0];
      end

      irq_ev = '0;
      irq_ev[`RSI_IRQ_DONE] = wait_done;
      irq_ev[`RSI_IRQ_WDT]  = wait_done && src == RSI_SRC_WDT;
      irq_ev[`RSI_IRQ_LVD]  = wait_done && src == RSI_SRC_LVD;
      next_irq_stat = irq_stat;
      if (wr_done && paddr == `RSI_OFF_IRQSTAT) begin
         next_irq_stat = irq_stat & ~pwdata[`RSI_IRQ_W-1:0];
      end
      next_irq_stat = next_irq_stat | irq_ev;
      next_irq_mask = irq_mask;
      if (wr_done && paddr == `RSI_OFF_IRQMASK) begin
         next_irq_mask = pwdata[`RSI_IRQ_W-1:0];
      end
      next_irq = |(next_irq_stat & next_irq_mask);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata   <= '0;
         pready   <= 1'b0;
         pslverr  <= 1'b0;
         wdt_flag <= 1'b0;
         lv_flag  <= 1'b0;
         lv_ctrl  <= `RSI_V00;
         lv_level <= `RSI_V00;
         irq_stat <= '0;
         irq_mask <= '0;
         irq      <= 1'b0;
      end else begin
         prdata   <= next_prdata;
         pready   <= next_pready;
         pslverr  <= next_pslverr;
         wdt_flag <= next_wdt_flag;
         lv_flag  <= next_lv_flag;
         lv_ctrl  <= next_lv_ctrl;
         lv_level <= next_lv_level;
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
         irq      <= next_irq;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_periph_held: assert property (any_req |=> !periph_rst_n && !cpu_run) else $error("periph not held");
   a_watchdog_enable_reg_opt: assert property (state == RSI_ST_HOLD |=>
      init_vals.watchdog_enable_reg == ($past(wdt_opt) ? 8'h9A : 8'h1A)) else $error("watchdog_enable_reg value");
   a_wdt_flag_set: assert property (state == RSI_ST_HOLD && src == RSI_SRC_WDT |=> wdt_flag)
      else $error("wdt flag");
   a_lv_flag_keep: assert property (state == RSI_ST_HOLD && src == RSI_SRC_WDT && !rd_done |=> $stable(lv_flag))
      else $error("lv flag");
   a_lv_regs_clr: assert property (state == RSI_ST_HOLD && src != RSI_SRC_LVD |=> lv_ctrl == 8'h00 && lv_level == 8'h00)
      else $error("lv regs");
   a_lv_regs_keep: assert property (state == RSI_ST_HOLD && src == RSI_SRC_LVD |=> $stable(lv_ctrl))
      else $error("lv keep");
   a_irq_vals: assert property (!cpu_run |-> init_vals.irq_mask_flags == 8'hFF && init_vals.irq_request_flags == 8'h00)
      else $error("irq vals");
   a_uart_a_vals: assert property (!cpu_run |-> init_vals.uart_a_baud_ctrl == 8'h1F && init_vals.uart_a_mode == 8'h01)
      else $error("uart a");
   a_uart_b_vals: assert property (!cpu_run |-> init_vals.uart_b_control == 8'h16 && init_vals.uart_b_baud_ctrl == 8'hFF)
      else $error("uart b");
   a_conv_vals: assert property (!cpu_run |-> init_vals.conv_result_wide == 16'h0000 && init_vals.conv_mode == 8'h00)
      else $error("conv");
   a_muldiv_vals: assert property (!cpu_run |-> init_vals.muldiv_remainder == 16'h0000 && init_vals.muldiv_control == 8'h00)
      else $error("muldiv");
   a_timer_vals: assert property (!cpu_run |-> init_vals.evt_counter == 8'h00 && init_vals.carrier_control == 8'h00)
      else $error("timers");
   a_serial_vals: assert property (!cpu_run |-> init_vals.i2c_regs == 8'h00 && init_vals.key_return_mode == 8'h00)
      else $error("serial");
   a_cause_rdclr: assert property (rd_done && paddr == `RSI_OFF_CAUSE && state == RSI_ST_RUN |=> !wdt_flag && !lv_flag)
      else $error("cause clear");
   a_src_poc: assert property (state == RSI_ST_RUN && req_poc |=> src == RSI_SRC_POC) else $error("src enc");

   c_wdt_reset: cover property (state == RSI_ST_HOLD && src == RSI_SRC_WDT ##1 wdt_flag);
   c_lvd_reset: cover property (state == RSI_ST_HOLD && src == RSI_SRC_LVD ##1 lv_flag);
   c_wait_done: cover property (wait_done ##1 cpu_run);
   c_irq_out: cover property (irq);
endmodule // rsi_reset_state_initializer

// ==== test/rsi_periph_model.sv ====
`timescale 1ns/100ps
module rsi_periph_model (
   // clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // reset image from the initializer
   input  wire logic               periph_rst_n,
   input  wire rsi_pkg::rsi_init_s init_vals,
   // registers as the peripherals hold them
   output rsi_pkg::rsi_init_s      periph_regs
);
   import rsi_pkg::*;

   // peripherals reload their images for as long as the reset line is low, then keep them
   always_ff @(posedge pclk) begin
      if (!presetn || !periph_rst_n) begin
         periph_regs <= init_vals;
      end
   end
endmodule // rsi_periph_model

// ==== test/rsi_reset_state_initializer_test.sv ====
`timescale 1ns/100ps
`include "rsi_regs.svh"
module rsi_reset_state_initializer_test;
   import rsi_pkg::*;
   localparam int IW = $bits(rsi_init_s);
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0]  reqs = 4'h0;
   logic        wdt_opt = 1'b1;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        periph_rst_n;
   logic        cpu_run;
   logic        irq;
   rsi_init_s   init_vals;
   rsi_init_s   periph_regs;
   int          fail_count = 0;
   int          total_checks = 0;

   always #2.5 pclk = ~pclk;

   rsi_reset_state_initializer #(.STAB_CYCLES(2)) dut (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .req_ext(reqs[0]), .req_poc(reqs[1]), .req_wdt(reqs[2]), .req_lvd(reqs[3]),
      .wdt_opt, .init_vals, .periph_rst_n, .cpu_run, .irq
   );

   rsi_periph_model model (.pclk, .presetn, .periph_rst_n, .init_vals, .periph_regs);

   function automatic rsi_init_s exp_img(input logic [7:0] w);
      return '{w, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff, 8'h01, 8'h00, 8'h1f,
               8'hff, 8'hff, 8'h01, 8'h00, 8'h00, 8'h00, 8'hff, 8'h16, 8'h00,
               16'h0000, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0000, 16'h0000, 16'h0000, 8'h00,
               8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   endfunction

   task automatic complete_run;
      $display("checks %0d errors %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [IW-1:0] seen, input logic [IW-1:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   // one apb transfer, entered and left on a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, q, e);
      chk(q, exp);
      chk(e, 1'b0);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask

   // while held in reset every image but the watchdog enable byte must already be final
   task automatic wait_run(input logic [7:0] w);
      logic [IW-1:0] ev;
      ev = exp_img(w);
      while (cpu_run !== 1'b1) begin
         chk(init_vals[IW-9:0], ev[IW-9:0]);
         chk(periph_rst_n, cpu_run);
         @(posedge pclk);
      end
      chk(periph_rst_n, 1'b1);
      chk(periph_regs, ev);
   endtask

   // one reset request of source k, then source code, detector registers and events
   task automatic step(input int k, input logic [7:0] w, input logic keep);
      wr(`RSI_OFF_LVCTRL, 8'h5a);
      wr(`RSI_OFF_LVLEVEL, 8'h3c);
      @(posedge pclk);
      reqs[k] <= 1'b1;
      @(posedge pclk);
      reqs <= 4'h0;
      @(posedge pclk);
      chk(cpu_run, 1'b0);
      wait_run(w);
      rd(`RSI_OFF_STATUS, 8'h04 | k);
      rd(`RSI_OFF_LVCTRL, keep ? 8'h5a : 8'h00);
      rd(`RSI_OFF_LVLEVEL, keep ? 8'h3c : 8'h00);
      rd(`RSI_OFF_IRQSTAT, 8'h01 | (k == 2 ? 8'h02 : 8'h00) | (k == 3 ? 8'h04 : 8'h00));
      chk(irq, 1'b1);
      wr(`RSI_OFF_IRQSTAT, 8'h07);
   endtask

   task automatic irq_after(input logic [11:0] a, input logic [31:0] d, input logic exp);
      wr(a, d);
      repeat (2) @(posedge pclk);
      chk(irq, exp);
   endtask

   initial begin
      #20000;
      fail_count++;
      complete_run;
   end

   initial begin
      logic [31:0] q;
      logic        e;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      wait_run(8'h9a);
      rd(`RSI_OFF_STATUS, 8'h05);
      rd(`RSI_OFF_CAUSE, 8'h00);
      rd(`RSI_OFF_IRQSTAT, 8'h01);
      chk(irq, 1'b0);
      irq_after(`RSI_OFF_IRQMASK, 8'h07, 1'b1);
      irq_after(`RSI_OFF_IRQMASK, 8'h00, 1'b0);
      irq_after(`RSI_OFF_IRQMASK, 8'h07, 1'b1);
      irq_after(`RSI_OFF_IRQSTAT, 8'h01, 1'b0);
      rd(`RSI_OFF_IRQSTAT, 8'h00);
      apb(1'b0, 12'h0fc, 32'h0000_0000, q, e);
      chk(q, 32'h0000_0000);
      chk(e, 1'b1);
      wr(`RSI_OFF_STATUS, 32'h0000_0000);
      rd(`RSI_OFF_STATUS, 8'h05);
      step(2, 8'h9a, 1'b0);
      step(3, 8'h9a, 1'b1);
      rd(`RSI_OFF_CAUSE, 8'h11);
      step(3, 8'h9a, 1'b1);
      step(2, 8'h9a, 1'b0);
      rd(`RSI_OFF_CAUSE, 8'h11);
      rd(`RSI_OFF_CAUSE, 8'h00);
      step(3, 8'h9a, 1'b1);
      wdt_opt <= 1'b0;
      step(0, 8'h1a, 1'b0);
      rd(`RSI_OFF_CAUSE, 8'h00);
      step(2, 8'h1a, 1'b0);
      step(1, 8'h1a, 1'b0);
      rd(`RSI_OFF_CAUSE, 8'h00);
      // second asynchronous reset in mid-run
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk(cpu_run, 1'b0);
      chk(init_vals, exp_img(8'h1a));
      presetn <= 1'b1;
      wait_run(8'h1a);
      rd(`RSI_OFF_STATUS, 8'h05);
      rd(`RSI_OFF_CAUSE, 8'h00);
      complete_run;
   end
endmodule // rsi_reset_state_initializer_test
